// [design/brf_block_ram_fifo_ecc.sv]
// How it works
// - 18 kb array, input, output, pipeline registers
// - single, true dual, pseudo dual port modes
// - shapes x1 to x36, no x36 in true dual
// - fifo counters with four flags, two of them on thresholds
// - optional parity bit stored per byte
// - byte enables only at x18 and x36
// - ecc data width fixed at 32 bits
// - check bits computed and stored on write
// - read checks word against stored check bits
// - single flipped bit corrected at output
// - separate single and double error outputs
// - each port has its own width
// - bits laid out word 0 lsb first
// - array preset at configuration time
// - rom mode preloaded, writes ignored
// - address and data registered at array input
// - read data direct or through register
// - output latches clear at the edge, async style also masks outputs at once
// - per port local output reset
// - global reset clears both output latches
// - pipeline registers reset the same way
module brf_block_ram_fifo_ecc
   import brf_pkg::*;
#(
   parameter logic [35:0] INIT_WORD = 36'h0
)
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_b,
   // register port
   input  wire logic [3:0]        reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [31:0]       reg_rdata,
   // memory ports, index 0 is port a, 1 is port b
   input  wire logic [1:0]        port_en,
   input  wire logic [1:0]        port_we,
   input  wire logic [1:0][13:0]  port_addr,
   input  wire logic [1:0][35:0]  port_wdata,
   input  wire logic [1:0][3:0]   port_byte_en,
   output logic      [1:0][35:0]  port_rdata,
   output logic      [1:0]        port_single_err,
   output logic      [1:0]        port_double_err,
   // output resets
   input  wire logic              port_a_output_reset,
   input  wire logic              port_b_output_reset,
   input  wire logic              global_set_reset_n,
   // fifo flags
   output logic                   fifo_full,
   output logic                   fifo_almost_full,
   output logic                   fifo_empty,
   output logic                   fifo_almost_empty
);

   typedef struct packed {
      brf_mode_t          mode;
      logic [1:0][2:0]    wid;
      logic               ecc;
      logic [1:0]         pipe;
      logic               par;
      logic               async_rst;
      logic [9:0]         af_thr;
      logic [9:0]         ae_thr;
      logic [1:0]         en;
      logic [1:0]         we;
      logic [1:0][13:0]   addr;
      logic [1:0][35:0]   wd;
      logic [1:0][3:0]    be;
      logic [1:0][35:0]   lat;
      logic [1:0]         lat_se;
      logic [1:0]         lat_de;
      logic [1:0][35:0]   pip;
      logic [1:0]         pip_se;
      logic [1:0]         pip_de;
      logic [9:0]         wptr;
      logic [9:0]         rptr;
      logic [9:0]         cnt;
      logic               st_se;
      logic               st_de;
      logic               st_cfg;
      logic [31:0]        rdat;
   } brf_state_t;

   brf_state_t s_q;
   brf_state_t s_d;

   // storage: flat bit array plus check bits per row
   logic mem [0:BRF_BITS-1];
   logic [BRF_ECC_W-1:0] emem [0:BRF_ROWS-1];

   // array access decode, filled by the comb process
   logic [1:0]        acc_wr;
   logic [1:0]        acc_rd;
   logic [1:0][19:0]  lin;
   logic [1:0][5:0]   wdt;
   logic [1:0][8:0]   row;
   logic [1:0][35:0]  wbits;
   logic [1:0][35:0]  wmask;
   logic [1:0][35:0]  rd_raw;
   logic [1:0]        rst_loc;

   function automatic logic [5:0] brf_width(input logic [2:0] c);
      case (c)
         BRF_W1:  return 6'h01;
         BRF_W2:  return 6'h02;
         BRF_W4:  return 6'h04;
         BRF_W9:  return 6'h09;
         BRF_W18: return 6'h12;
         default: return 6'h24;
      endcase
   endfunction

   // data bits go to the non power of two positions 3..38
   function automatic logic [38:0] brf_place(input logic [31:0] d);
      logic [38:0] c;
      int          j;
      c = '0;
      j = 0;
      for (int p = 1; p < 39; p++)
      begin
         if ((p & (p - 1)) != 0)
         begin
            c[p] = d[j];
            j++;
         end
      end
      return c;
   endfunction

   // hamming secded check bits, bit 6 is overall parity
   function automatic logic [6:0] brf_ecc_enc(input logic [31:0] d);
      logic [38:0] c;
      logic [6:0]  k;
      c = brf_place(d);
      k = '0;
      for (int b = 0; b < 6; b++)
      begin
         for (int p = 1; p < 39; p++)
         begin
            if (p[b])
               k[b] ^= c[p];
         end
      end
      k[6] = (^c) ^ (^k[5:0]);
      return k;
   endfunction

   // returns {double, single, corrected data}
   function automatic logic [33:0] brf_ecc_dec(input logic [31:0] d, input logic [6:0] k);
      logic [38:0] c;
      logic [5:0]  sy;
      logic        ov;
      logic [31:0] o;
      int          j;
      c = brf_place(d);
      sy = '0;
      o = '0;
      j = 0;
      for (int b = 0; b < 6; b++)
         c[1 << b] = k[b];
      c[0] = k[6];
      for (int b = 0; b < 6; b++)
      begin
         for (int p = 1; p < 39; p++)
         begin
            if (p[b])
               sy[b] ^= c[p];
         end
      end
      ov = ^c;
      if (ov && sy != 6'h00 && sy < 6'h27)
         c[sy] = ~c[sy];
      for (int p = 1; p < 39; p++)
      begin
         if ((p & (p - 1)) != 0)
         begin
            o[j] = c[p];
            j++;
         end
      end
      // syndrome beyond the codeword means more than one flip
      return {(!ov && sy != 6'h00) || (ov && sy >= 6'h27), ov && sy < 6'h27, o};
   endfunction

   // preset contents at configuration, check bits kept consistent
   initial
   begin
      for (int r = 0; r < BRF_ROWS; r++)
      begin
         for (int i = 0; i < BRF_ROW_W; i++)
            mem[r * BRF_ROW_W + i] = INIT_WORD[i];
         emem[r] = brf_ecc_enc(INIT_WORD[31:0]);
      end
   end

   assign rst_loc[0] = port_a_output_reset || !global_set_reset_n;
   assign rst_loc[1] = port_b_output_reset || !global_set_reset_n;

   // next state: access decode, output latches, fifo, registers
   always_comb
   begin
      logic [33:0] dec;
      logic [35:0] rdv;
      logic        cfg_bad;
      logic        se_new;
      logic        de_new;
      logic [14:0] idx;
      dec = '0;
      rdv = '0;
      cfg_bad = 1'b0;
      se_new = 1'b0;
      de_new = 1'b0;
      idx = '0;
      s_d = s_q;
      // input registers in front of the array
      s_d.en = port_en;
      s_d.we = port_we;
      s_d.addr = port_addr;
      s_d.wd = port_wdata;
      s_d.be = port_byte_en;
      for (int p = 0; p < 2; p++)
      begin
         // each port keeps its own width unless ecc fixes it at 32 or fifo mode at 36
         wdt[p] = s_q.ecc ? 6'h20 : brf_width(s_q.wid[p]);
         row[p] = s_q.addr[p][8:0];
         if (s_q.mode == BRF_FIFO)
         begin
            wdt[p] = 6'h24;
            row[p] = (p == 0) ? s_q.wptr[8:0] : s_q.rptr[8:0];
         end
         // word n starts at bit n times width (n times 36 with ecc), lsb first
         if (s_q.ecc || s_q.mode == BRF_FIFO)
            lin[p] = 20'({11'h0, row[p]} * 20'(BRF_ROW_W));
         else
            lin[p] = 20'({6'h0, s_q.addr[p]} * {14'h0, wdt[p]});
         acc_wr[p] = s_q.en[p] && s_q.we[p] && lin[p] < 20'(BRF_BITS);
         acc_rd[p] = s_q.en[p] && !s_q.we[p] && lin[p] < 20'(BRF_BITS);
         case (s_q.mode)
            BRF_SP:
            begin
               if (p == 1)
               begin
                  acc_wr[p] = 1'b0;
                  acc_rd[p] = 1'b0;
               end
            end
            BRF_TDP:
            begin
               if (!s_q.ecc && s_q.wid[p] == BRF_W36)
               begin
                  cfg_bad = cfg_bad || s_q.en[p];
                  acc_wr[p] = 1'b0;
                  acc_rd[p] = 1'b0;
               end
            end
            BRF_PDP:
            begin
               if (p == 0)
                  acc_rd[p] = 1'b0;
               else
                  acc_wr[p] = 1'b0;
            end
            BRF_ROM:
               acc_wr[p] = 1'b0;
            BRF_FIFO:
            begin
               // writes on a, reads on b, refused at full or empty
               acc_wr[p] = (p == 0) && s_q.en[0] && s_q.we[0] && s_q.cnt != BRF_FIFO_MAX;
               acc_rd[p] = (p == 1) && s_q.en[1] && s_q.cnt != 10'h000;
            end
            default:
            begin
               acc_wr[p] = 1'b0;
               acc_rd[p] = 1'b0;
            end
         endcase
         // write bits with byte parity and byte lane masks
         for (int i = 0; i < 36; i++)
         begin
            wbits[p][i] = s_q.wd[p][i];
            if (s_q.par && !s_q.ecc && (i % 9) == 8 && (wdt[p] == 6'h09 || wdt[p] == 6'h12 || wdt[p] == 6'h24))
               wbits[p][i] = ^s_q.wd[p][(i / 9) * 9 +: 8];
            wmask[p][i] = i < wdt[p];
            if ((wdt[p] == 6'h12 || wdt[p] == 6'h24) && !s_q.be[p][i / 9])
               wmask[p][i] = 1'b0;
         end
         // raw array read
         for (int i = 0; i < 36; i++)
         begin
            idx = lin[p][14:0] + 15'(i);
            rd_raw[p][i] = (i < wdt[p]) ? mem[idx] : 1'b0;
         end
         rdv = rd_raw[p];
         dec = '0;
         if (s_q.ecc)
         begin
            dec = brf_ecc_dec(rd_raw[p][31:0], emem[row[p]]);
            rdv = {4'h0, dec[31:0]};
         end
         // output latch, then optional pipeline register
         if (rst_loc[p])
         begin
            s_d.lat[p] = '0;
            s_d.lat_se[p] = 1'b0;
            s_d.lat_de[p] = 1'b0;
         end
         else if (acc_rd[p])
         begin
            s_d.lat[p] = rdv;
            s_d.lat_se[p] = dec[32];
            s_d.lat_de[p] = dec[33];
            se_new = se_new || dec[32];
            de_new = de_new || dec[33];
         end
         if (rst_loc[p])
         begin
            s_d.pip[p] = '0;
            s_d.pip_se[p] = 1'b0;
            s_d.pip_de[p] = 1'b0;
         end
         else
         begin
            s_d.pip[p] = s_q.lat[p];
            s_d.pip_se[p] = s_q.lat_se[p];
            s_d.pip_de[p] = s_q.lat_de[p];
         end
      end
      // fifo counters move on the one clock
      s_d.wptr = s_q.wptr + {9'h0, acc_wr[0] && s_q.mode == BRF_FIFO};
      s_d.rptr = s_q.rptr + {9'h0, acc_rd[1] && s_q.mode == BRF_FIFO};
      if (s_q.mode == BRF_FIFO)
         s_d.cnt = s_q.cnt + {9'h0, acc_wr[0]} - {9'h0, acc_rd[1]};
      if (s_q.wptr[9] != s_d.wptr[9])
         s_d.wptr[9] = 1'b0;
      if (s_q.rptr[9] != s_d.rptr[9])
         s_d.rptr[9] = 1'b0;
      // register writes; set of a sticky bit beats its clear
      if (reg_wr && reg_addr == BRF_REG_CFG)
      begin
         s_d.mode = brf_mode_t'(reg_wdata[BRF_CFG_MODE +: 3]);
         s_d.wid[0] = reg_wdata[BRF_CFG_WID_A +: 3];
         s_d.wid[1] = reg_wdata[BRF_CFG_WID_B +: 3];
         s_d.ecc = reg_wdata[BRF_CFG_ECC];
         s_d.pipe[0] = reg_wdata[BRF_CFG_PIPEA];
         s_d.pipe[1] = reg_wdata[BRF_CFG_PIPEB];
         s_d.par = reg_wdata[BRF_CFG_PAR];
         s_d.async_rst = reg_wdata[BRF_CFG_ASYNC];
         // any configuration write restarts the fifo empty
         s_d.wptr = '0;
         s_d.rptr = '0;
         s_d.cnt = '0;
      end
      else if (reg_wr && reg_addr == BRF_REG_THR)
      begin
         s_d.af_thr = reg_wdata[9:0];
         s_d.ae_thr = reg_wdata[BRF_THR_AE +: 10];
      end
      else if (reg_wr && reg_addr == BRF_REG_STAT)
      begin
         s_d.st_se = s_q.st_se && !reg_wdata[BRF_ST_SERR];
         s_d.st_de = s_q.st_de && !reg_wdata[BRF_ST_DERR];
         s_d.st_cfg = s_q.st_cfg && !reg_wdata[BRF_ST_CFGE];
      end
      s_d.st_se = s_d.st_se || se_new;
      s_d.st_de = s_d.st_de || de_new;
      s_d.st_cfg = s_d.st_cfg || cfg_bad;
      // register reads answer one cycle later
      s_d.rdat = '0;
      if (reg_rd && reg_addr == BRF_REG_CFG)
      begin
         s_d.rdat[BRF_CFG_MODE +: 3] = s_q.mode;
         s_d.rdat[BRF_CFG_WID_A +: 3] = s_q.wid[0];
         s_d.rdat[BRF_CFG_WID_B +: 3] = s_q.wid[1];
         s_d.rdat[BRF_CFG_ECC] = s_q.ecc;
         s_d.rdat[BRF_CFG_PIPEA] = s_q.pipe[0];
         s_d.rdat[BRF_CFG_PIPEB] = s_q.pipe[1];
         s_d.rdat[BRF_CFG_PAR] = s_q.par;
         s_d.rdat[BRF_CFG_ASYNC] = s_q.async_rst;
      end
      else if (reg_rd && reg_addr == BRF_REG_THR)
      begin
         s_d.rdat[9:0] = s_q.af_thr;
         s_d.rdat[BRF_THR_AE +: 10] = s_q.ae_thr;
      end
      else if (reg_rd && reg_addr == BRF_REG_STAT)
      begin
         s_d.rdat[BRF_ST_FULL] = fifo_full;
         s_d.rdat[BRF_ST_AFULL] = fifo_almost_full;
         s_d.rdat[BRF_ST_EMPTY] = fifo_empty;
         s_d.rdat[BRF_ST_AEMPT] = fifo_almost_empty;
         s_d.rdat[BRF_ST_SERR] = s_q.st_se;
         s_d.rdat[BRF_ST_DERR] = s_q.st_de;
         s_d.rdat[BRF_ST_CFGE] = s_q.st_cfg;
         s_d.rdat[BRF_ST_CNT +: 10] = s_q.cnt;
      end
   end

   // state register
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         s_q <= '0;
         s_q.mode <= BRF_SP;
         s_q.wid <= {BRF_WID_RST, BRF_WID_RST};
         s_q.af_thr <= BRF_AF_RST;
         s_q.ae_thr <= BRF_AE_RST;
      end
      else
         s_q <= s_d;
   end

   // array writes one cycle after capture; b lands last on a collision
   // plain always: the configuration preset above also writes the array
   always @(posedge clk)
   begin
      for (int p = 0; p < 2; p++)
      begin
         if (rst_b && acc_wr[p])
         begin
            for (int i = 0; i < 36; i++)
            begin
               if (wmask[p][i])
                  mem[lin[p][14:0] + 15'(i)] <= wbits[p][i];
            end
            if (s_q.ecc)
               emem[row[p]] <= brf_ecc_enc(wbits[p][31:0]);
         end
      end
   end

   // async reset style masks outputs while the reset is held
   always_comb
   begin
      for (int p = 0; p < 2; p++)
      begin
         port_rdata[p] = s_q.pipe[p] ? s_q.pip[p] : s_q.lat[p];
         port_single_err[p] = s_q.pipe[p] ? s_q.pip_se[p] : s_q.lat_se[p];
         port_double_err[p] = s_q.pipe[p] ? s_q.pip_de[p] : s_q.lat_de[p];
         if (s_q.async_rst && rst_loc[p])
         begin
            port_rdata[p] = '0;
            port_single_err[p] = 1'b0;
            port_double_err[p] = 1'b0;
         end
      end
   end

   // fifo flags straight from the registered count
   assign fifo_full = s_q.cnt == BRF_FIFO_MAX;
   assign fifo_empty = s_q.cnt == 10'h000;
   assign fifo_almost_full = s_q.cnt >= s_q.af_thr;
   assign fifo_almost_empty = s_q.cnt <= s_q.ae_thr;
   assign reg_rdata = s_q.rdat;

endmodule

// [design/brf_pkg.sv]
package brf_pkg;
   // storage geometry
   localparam int unsigned BRF_BITS   = 18432;
   localparam int unsigned BRF_ROWS   = 512;
   localparam int unsigned BRF_ROW_W  = 36;
   localparam int unsigned BRF_ECC_W  = 7;
   localparam int unsigned BRF_DATA_W = 32;

   // register byte offsets
   localparam logic [3:0] BRF_REG_CFG  = 4'h0;
   localparam logic [3:0] BRF_REG_THR  = 4'h4;
   localparam logic [3:0] BRF_REG_STAT = 4'h8;

   // configuration field positions
   localparam int unsigned BRF_CFG_MODE  = 0;
   localparam int unsigned BRF_CFG_WID_A = 3;
   localparam int unsigned BRF_CFG_WID_B = 6;
   localparam int unsigned BRF_CFG_ECC   = 9;
   localparam int unsigned BRF_CFG_PIPEA = 10;
   localparam int unsigned BRF_CFG_PIPEB = 11;
   localparam int unsigned BRF_CFG_PAR   = 12;
   localparam int unsigned BRF_CFG_ASYNC = 13;
   localparam int unsigned BRF_THR_AE    = 16;

   // status bit positions
   localparam int unsigned BRF_ST_FULL  = 0;
   localparam int unsigned BRF_ST_AFULL = 1;
   localparam int unsigned BRF_ST_EMPTY = 2;
   localparam int unsigned BRF_ST_AEMPT = 3;
   localparam int unsigned BRF_ST_SERR  = 4;
   localparam int unsigned BRF_ST_DERR  = 5;
   localparam int unsigned BRF_ST_CFGE  = 6;
   localparam int unsigned BRF_ST_CNT   = 16;

   // values after reset, and the fifo depth
   localparam logic [2:0] BRF_WID_RST = 3'h5;
   localparam logic [9:0] BRF_AF_RST  = 10'h1E0;
   localparam logic [9:0] BRF_AE_RST  = 10'h020;
   localparam logic [9:0] BRF_FIFO_MAX = 10'h200;

   typedef enum logic [2:0] {
      BRF_SP   = 3'b000,
      BRF_TDP  = 3'b001,
      BRF_PDP  = 3'b010,
      BRF_ROM  = 3'b011,
      BRF_FIFO = 3'b100
   } brf_mode_t;

   // port width codes: x1 x2 x4 x9 x18 x36
   typedef enum logic [2:0] {
      BRF_W1  = 3'b000,
      BRF_W2  = 3'b001,
      BRF_W4  = 3'b010,
      BRF_W9  = 3'b011,
      BRF_W18 = 3'b100,
      BRF_W36 = 3'b101
   } brf_wid_t;
endpackage

// [verification/brf_checker_assertions.sv]
module brf_checker
   import brf_pkg::*;
(
   // clock and reset
   input wire logic             clk,
   input wire logic             rst_b,
   // register port
   input wire logic             reg_wr,
   // memory ports
   input wire logic [1:0]       port_en,
   input wire logic [1:0]       port_we,
   input wire logic [1:0][35:0] port_rdata,
   input wire logic [1:0]       port_single_err,
   input wire logic [1:0]       port_double_err,
   // output resets
   input wire logic             port_a_output_reset,
   input wire logic             port_b_output_reset,
   input wire logic             global_set_reset_n,
   // fifo flags
   input wire logic             fifo_full,
   input wire logic             fifo_empty,
   input wire logic             fifo_almost_empty
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   // flags leave reset showing an empty fifo
   a_flags_after_reset: assert property ($rose(rst_b) |-> fifo_empty && fifo_almost_empty && !fifo_full)
      else $error("fifo flags wrong after reset");
   a_empty_not_full: assert property (!(fifo_empty && fifo_full))
      else $error("fifo empty and full together");
   a_empty_almost: assert property (fifo_empty |-> fifo_almost_empty)
      else $error("empty without almost empty");
   // count moves only one edge after a capture, so two quiet edges keep a flag
   a_empty_holds: assert property (!(port_en[0] && port_we[0]) ##1 (fifo_empty && !(port_en[0] && port_we[0]))
      |=> fifo_empty)
      else $error("fifo empty dropped without a write");
   a_full_holds: assert property (!port_en[1] ##1 (fifo_full && !port_en[1] && !reg_wr) |=> fifo_full)
      else $error("fifo full dropped without a read");
   // local resets clear latch and pipe of their own port
   a_reset_port_a: assert property (port_a_output_reset |=> port_rdata[0] == 36'h0)
      else $error("port a output not cleared");
   a_reset_port_b: assert property (port_b_output_reset |=> port_rdata[1] == 36'h0)
      else $error("port b output not cleared");
   a_global_clears: assert property (!global_set_reset_n |=> port_rdata == '0)
      else $error("global reset left output data");
   a_err_exclusive: assert property ((port_single_err & port_double_err) == 2'b00)
      else $error("single and double error together");
endmodule

// [verification/brf_fabric_user.sv]
module brf_fabric_user
   import brf_pkg::*;
(
   // clock
   input  wire logic             clk,
   // requests toward the memory
   output logic      [1:0]       port_en,
   output logic      [1:0]       port_we,
   output logic      [1:0][13:0] port_addr,
   output logic      [1:0][35:0] port_wdata,
   output logic      [1:0][3:0]  port_byte_en,
   // answers
   input  wire logic [1:0][35:0] port_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   // quiet lines at time zero
   initial
   begin
      port_en      = '0;
      port_we      = '0;
      port_addr    = '0;
      port_wdata   = '0;
      port_byte_en = '1;
   end

   // one access held to its capture edge; released lines turn to junk
   task automatic op(input int p, input logic we, input logic [13:0] a,
                     input logic [35:0] d, input int lat, output logic [35:0] q);
      @(posedge clk);
      port_en[p]    <= 1'b1;
      port_we[p]    <= we;
      port_addr[p]  <= a;
      port_wdata[p] <= d;
      @(posedge clk);
      port_en[p]    <= 1'b0;
      port_we[p]    <= ~we;
      port_addr[p]  <= ~a;
      port_wdata[p] <= ~d;
      repeat (lat) @(posedge clk);
      #1 q = port_rdata[p];
   endtask

   // byte lane enables for the following accesses of one port
   task automatic lanes(input int p, input logic [3:0] m);
      @(posedge clk);
      port_byte_en[p] <= m;
   endtask
endmodule

// [verification/test_block_ram_fifo_ecc.sv]
module test_block_ram_fifo_ecc;
   timeunit 1ns;
   timeprecision 1ps;

   // bench signals
   logic             clk = 1'b0;
   logic             rst_b = 1'b0;
   logic [3:0]       reg_addr = '0;
   logic [31:0]      reg_wdata = '0;
   logic             reg_wr = 1'b0;
   logic             reg_rd = 1'b0;
   logic [31:0]      reg_rdata;
   logic [1:0]       port_en;
   logic [1:0]       port_we;
   logic [1:0][13:0] port_addr;
   logic [1:0][35:0] port_wdata;
   logic [1:0][3:0]  port_byte_en;
   logic [1:0][35:0] port_rdata;
   logic [1:0]       port_single_err;
   logic [1:0]       port_double_err;
   logic             port_a_output_reset = 1'b0;
   logic             port_b_output_reset = 1'b0;
   logic             global_set_reset_n = 1'b1;
   logic             fifo_full;
   logic             fifo_almost_full;
   logic             fifo_empty;
   logic             fifo_almost_empty;
   logic [35:0]      q;
   logic [31:0]      r;
   int               bad_count = 0;
   int               samples_checked = 0;
   localparam logic [31:0] DW = 32'h1234ABCD;
   localparam int    BITS[4] = '{0, 1, 2, 35};

   always #2.5 clk = ~clk;

   brf_block_ram_fifo_ecc i_brf_block_ram_fifo_ecc (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .port_en, .port_we, .port_addr, .port_wdata, .port_byte_en, .port_rdata,
      .port_single_err, .port_double_err, .port_a_output_reset, .port_b_output_reset,
      .global_set_reset_n, .fifo_full, .fifo_almost_full, .fifo_empty, .fifo_almost_empty);

   brf_fabric_user i_brf_fabric_user (.clk, .port_en, .port_we, .port_addr, .port_wdata,
      .port_byte_en, .port_rdata);

   task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      if (bad_count == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // register write and read, strobes one cycle long
   task automatic rw(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rc(input string nm, input logic [3:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 r = reg_rdata;
      chk(nm, {4'h0, r}, {4'h0, e});
   endtask

   // memory accesses through the fabric model
   task automatic mw(input int p, input logic [13:0] a, input logic [35:0] d);
      i_brf_fabric_user.op(p, 1'b1, a, d, 0, q);
   endtask

   task automatic mr(input string nm, input int p, input logic [13:0] a, input int lat, input logic [35:0] e);
      i_brf_fabric_user.op(p, 1'b0, a, '0, lat, q);
      chk(nm, q, e);
   endtask

   // hang guard
   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count++;
      tally_and_finish();
   end

   initial
   begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      // reset values and an unmapped hole
      rc("cfg", 4'h0, 32'h00000168);
      rc("thr", 4'h4, 32'h002001E0);
      rc("stat", 4'h8, 32'h0000000C);
      rw(4'hC, 32'hFFFFFFFF);
      rc("hole", 4'hC, 32'h0);
      // clean ecc word, then one and two flipped bits behind the engine's back
      rw(4'h0, 32'h228);
      mw(0, 14'd3, {4'h0, DW});
      mr("ecc clean", 0, 14'd3, 1, {4'h0, DW});
      chk("serr clean", port_single_err[0], 1'b0);
      for (int k = 1; k < 3; k++)
      begin
         rw(4'h0, 32'h28);
         mw(0, 14'd3, {4'h0, DW ^ ((32'h1 << k) - 32'h1)});
         rw(4'h0, 32'h228);
         i_brf_fabric_user.op(0, 1'b0, 14'd3, '0, 1, q);
         if (k == 1)
            chk("ecc fix", q, {4'h0, DW});
         chk("serr", port_single_err[0], k == 1);
         chk("derr", port_double_err[0], k == 2);
      end
      rw(4'h0, 32'h22A);
      mr("ecc b", 1, 14'd3, 1, {4'h0, DW ^ 32'h3});
      chk("errs b", {port_single_err[1], port_double_err[1]}, 2'b01);
      rc("sticky", 4'h8, 32'h0000003C);
      rw(4'h8, 32'h70);
      rc("cleared", 4'h8, 32'h0000000C);
      // rom drops writes, true dual refuses x36
      rw(4'h0, 32'h16B);
      mw(0, 14'd3, 36'h0);
      mr("rom", 0, 14'd3, 1, {4'h0, DW ^ 32'h3});
      rw(4'h0, 32'h169);
      mw(0, 14'd3, 36'h0);
      rc("tdp x36", 4'h8, 32'h0000004C);
      rw(4'h8, 32'h70);
      // pseudo dual: x36 in on a, x1 out on b
      rw(4'h0, 32'h2A);
      mw(0, 14'd0, 36'h800000005);
      foreach (BITS[i])
         mr("x1 bit", 1, 14'(BITS[i]), 1, {35'h0, BITS[i] != 1});
      // pipe on port b adds one cycle
      rw(4'h0, 32'h82A);
      mr("pipe", 1, 14'd35, 2, 36'h1);
      mr("pipe early", 1, 14'd1, 1, 36'h1);
      @(posedge clk);
      #1 chk("pipe late", port_rdata[1], 36'h0);
      mr("pipe again", 1, 14'd35, 2, 36'h1);
      @(posedge clk);
      port_b_output_reset <= 1'b1;
      @(posedge clk);
      port_b_output_reset <= 1'b0;
      #1 chk("b reset", port_rdata[1], 36'h0);
      chk("a kept", port_rdata[0], {4'h0, DW ^ 32'h3});
      // async style clears at once, sync style at the edge
      rw(4'h0, 32'h2028);
      mr("sp", 0, 14'd3, 1, {4'h0, DW ^ 32'h3});
      @(posedge clk);
      port_a_output_reset <= 1'b1;
      #1 chk("async a", port_rdata[0], 36'h0);
      @(posedge clk);
      port_a_output_reset <= 1'b0;
      rw(4'h0, 32'h28);
      mr("sp", 0, 14'd3, 1, {4'h0, DW ^ 32'h3});
      @(posedge clk);
      global_set_reset_n <= 1'b0;
      #1 chk("sync wait", port_rdata[0], {4'h0, DW ^ 32'h3});
      @(posedge clk);
      global_set_reset_n <= 1'b1;
      #1 chk("gsr a", port_rdata[0], 36'h0);
      chk("gsr b", port_rdata[1], 36'h0);
      // parity bit per byte at x9, lane enables ignored at x9 and used at x18
      rw(4'h0, 32'h1018);
      i_brf_fabric_user.lanes(0, 4'h0);
      mw(0, 14'd100, 36'h007);
      mr("parity", 0, 14'd100, 1, 36'h107);
      rw(4'h0, 32'h20);
      i_brf_fabric_user.lanes(0, 4'h1);
      mw(0, 14'd200, 36'h3FFFF);
      i_brf_fabric_user.lanes(0, 4'hF);
      mr("byte lanes", 0, 14'd200, 1, 36'h001FF);
      // fifo filled past full, then drained in order
      rw(4'h0, 32'h4);
      rw(4'h4, 32'h00010003);
      rc("thr set", 4'h4, 32'h00010003);
      for (int i = 0; i < 512; i++)
         mw(0, 14'd0, 36'(i));
      rc("full stat", 4'h8, 32'h02000003);
      chk("full", fifo_full, 1'b1);
      mw(0, 14'd0, 36'hFFF);
      rc("refused", 4'h8, 32'h02000003);
      for (int i = 0; i < 512; i++)
      begin
         mr("fifo data", 1, 14'd0, 1, 36'(i));
         chk("afull", fifo_almost_full, i <= 508);
         chk("aempty", fifo_almost_empty, i >= 510);
      end
      chk("empty", fifo_empty, 1'b1);
      rc("empty stat", 4'h8, 32'h0000000C);
      tally_and_finish();
   end
endmodule

bind brf_block_ram_fifo_ecc brf_checker i_brf_checker (.clk, .rst_b, .reg_wr, .port_en, .port_we,
   .port_rdata, .port_single_err, .port_double_err, .port_a_output_reset, .port_b_output_reset,
   .global_set_reset_n, .fifo_full, .fifo_empty, .fifo_almost_empty);
